// *** design/prb_pkg.sv ***
package prb_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_IRQ      = 8'h08;
	localparam logic [7:0]  REG_BEC      = 8'h0C;
	localparam logic [9:0]  CTRL_RST     = 10'h000;
	localparam logic [22:0] GEN_SEED     = 23'h7FFFFF;

	// ----------------------------------------------------------------
	// pattern status codes
	// ----------------------------------------------------------------
	localparam logic [2:0]  ST_NONE      = 3'h0;
	localparam logic [2:0]  ST_TRUE      = 3'h1;
	localparam logic [2:0]  ST_INV       = 3'h2;
	localparam logic [2:0]  ST_IDENT     = 3'h6;

	// ----------------------------------------------------------------
	// monitor counts, in received bits
	// ----------------------------------------------------------------
	localparam logic [5:0]  LOCK_RUN     = 6'h20;
	localparam logic [5:0]  WIN_LEN      = 6'h3F;
	localparam logic [5:0]  WIN_ERR_MAX  = 6'h18;
	localparam logic [4:0]  IDENT_11     = 5'h0C;
	localparam logic [4:0]  IDENT_15     = 5'h10;
	localparam logic [4:0]  IDENT_20     = 5'h15;
	localparam logic [4:0]  IDENT_23     = 5'h18;
	localparam logic [15:0] BEC_MAX      = 16'hFFFF;

	typedef enum logic {MS_SEARCH, MS_LOCK} prb_mon_t;

	typedef struct packed {
		logic       t1_mode;
		logic       alarm_sim;
		logic [1:0] pattern_mode;
		logic [1:0] polynomial_select;
		logic       legacy_polynomial_select;
		logic       tx_pattern_invert;
		logic       tx_pattern_enable;
		logic       rx_pattern_monitor_enable;
	} prb_ctrl_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wr_data;
		logic        wr;
		logic        rd;
	} prb_bus_t;

	// feedback bit of the selected sequence; shifting it in gives the next bit
	function automatic logic prb_fb(input logic [22:0] r, input logic [1:0] sel);
		logic b;
		b = 1'b0;
		case (sel)
			2'h0: b = r[10] ^ r[8];
			2'h1: b = r[14] ^ r[13];
			2'h2: b = r[19] ^ r[16];
			default: b = r[22] ^ r[17];
		endcase
		return b;
	endfunction

endpackage

// *** design/prb_core.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module prb_core (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// register port
	input  wire prb_pkg::prb_bus_t bus,
	output logic [31:0]            rd_data,
	// transmit bit stream
	input  wire logic              tx_bit_en,
	input  wire logic              tx_data,
	output logic                   tx_line,
	// receive bit stream
	input  wire logic              rx_bit_en,
	input  wire logic              rx_bit,
	// loop code status change events
	input  wire logic              loop_status_event
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		prb_pkg::prb_ctrl_t ctrl;
		logic               mon_en_d;
		logic [22:0]        gen;
		logic               tx_line;
		logic [22:0]        shr;
		logic [22:0]        refr;
		prb_pkg::prb_mon_t  mstate;
		logic               inv;
		logic [5:0]         run;
		logic [4:0]         ident_run;
		logic [5:0]         win_cnt;
		logic [5:0]         win_err;
		logic [2:0]         status;
		logic [1:0]         first_lock;
		logic               irq_e1;
		logic               irq_t1;
		logic [15:0]        bec;
		logic [31:0]        rd_data;
	} prb_core_state_t;

	prb_core_state_t st;
	prb_core_state_t next_st;

	logic [1:0]  eff_sel;
	logic [4:0]  ident_thr;
	logic        ident_now;
	logic        mon_rise;
	logic        gen_bit;
	logic        pred;
	logic        exp_bit;
	logic        bit_err;
	logic        bec_inc;
	logic        change;
	logic [2:0]  next_status;

	assign rd_data = st.rd_data;
	assign tx_line = st.tx_line;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (st.ctrl.pattern_mode == 2'h0) begin
			eff_sel = st.ctrl.legacy_polynomial_select ? 2'h2 : 2'h1;
		end else begin
			eff_sel = st.ctrl.polynomial_select;
		end
		case (eff_sel)
			2'h0: ident_thr = prb_pkg::IDENT_11;
			2'h1: ident_thr = prb_pkg::IDENT_15;
			2'h2: ident_thr = prb_pkg::IDENT_20;
			default: ident_thr = prb_pkg::IDENT_23;
		endcase
		// raw received bits, tx invert not involved
		ident_now = st.ident_run >= ident_thr;
		mon_rise  = st.ctrl.rx_pattern_monitor_enable & ~st.mon_en_d;
		next_st.mon_en_d = st.ctrl.rx_pattern_monitor_enable;

		// generator
		// polynomial sequence
		gen_bit = prb_pkg::prb_fb(st.gen, eff_sel);
		if (tx_bit_en) begin
			next_st.gen = {st.gen[21:0], gen_bit};
			if (st.ctrl.tx_pattern_enable) begin
				next_st.tx_line = gen_bit ^ st.ctrl.tx_pattern_invert;
			end else begin
				next_st.tx_line = tx_data;
			end
		end

		// monitor
		pred    = prb_pkg::prb_fb(st.shr, eff_sel);
		exp_bit = prb_pkg::prb_fb(st.refr, eff_sel);
		bit_err = 1'b0;
		if (mon_rise) begin
			next_st.mstate     = prb_pkg::MS_SEARCH;
			next_st.run        = 6'h00;
			next_st.ident_run  = 5'h00;
			next_st.first_lock = 2'h0;
		end else if (st.ctrl.rx_pattern_monitor_enable && rx_bit_en) begin
			next_st.shr = {st.shr[21:0], rx_bit};
			if (rx_bit == st.shr[0]) begin
				if (st.ident_run != 5'h1F) begin
					next_st.ident_run = st.ident_run + 5'h01;
				end
			end else begin
				next_st.ident_run = 5'h01;
			end
			case (st.mstate)
				prb_pkg::MS_SEARCH: begin
					if (ident_now) begin
						next_st.run = 6'h00;
					end else if ((rx_bit ^ pred) == st.inv && st.run != 6'h00) begin
						next_st.run = st.run + 6'h01;
					end else begin
						next_st.inv = rx_bit ^ pred;
						next_st.run = 6'h01;
					end
					// lock on true or inverted form
					if (!ident_now && st.run == prb_pkg::LOCK_RUN - 6'h01
					    && (rx_bit ^ pred) == st.inv) begin
						next_st.mstate  = prb_pkg::MS_LOCK;
						next_st.refr    = st.inv ? ~{st.shr[21:0], rx_bit} : {st.shr[21:0], rx_bit};
						next_st.win_cnt = 6'h00;
						next_st.win_err = 6'h00;
						if (st.first_lock == 2'h0) begin
							next_st.first_lock = st.inv ? 2'h2 : 2'h1;
						end
					end
				end
				prb_pkg::MS_LOCK: begin
					next_st.refr = {st.refr[21:0], exp_bit};
					bit_err      = rx_bit ^ st.inv ^ exp_bit;
					if (st.win_cnt == prb_pkg::WIN_LEN) begin
						next_st.win_cnt = 6'h00;
						next_st.win_err = {5'h00, bit_err};
					end else begin
						next_st.win_cnt = st.win_cnt + 6'h01;
						next_st.win_err = st.win_err + {5'h00, bit_err};
					end
					if (ident_now || next_st.win_err >= prb_pkg::WIN_ERR_MAX) begin
						next_st.mstate = prb_pkg::MS_SEARCH;
						next_st.run    = 6'h00;
					end
				end
				default: begin
					next_st.mstate = prb_pkg::MS_SEARCH;
				end
			endcase
		end

		if (!st.ctrl.rx_pattern_monitor_enable || st.ctrl.alarm_sim) begin
			next_status = prb_pkg::ST_NONE;
		end else if (ident_now) begin
			next_status = prb_pkg::ST_IDENT;
		end else if (st.mstate == prb_pkg::MS_LOCK) begin
			next_status = st.inv ? prb_pkg::ST_INV : prb_pkg::ST_TRUE;
		end else begin
			next_status = prb_pkg::ST_NONE;
		end
		next_st.status = next_status;

		if (st.ctrl.rx_pattern_monitor_enable) begin
			change = (next_status != st.status) || (st.status[2:1] == 2'h3);
		end else begin
			change = loop_status_event;
		end

		bec_inc = bit_err && st.bec != prb_pkg::BEC_MAX;

		// register port; hardware set wins over read clear
		next_st.rd_data = 32'h00000000;
		if (bus.wr && bus.addr == prb_pkg::REG_CTRL) begin
			next_st.ctrl = prb_pkg::prb_ctrl_t'(bus.wr_data[9:0]);
		end
		if (bus.rd) begin
			case (bus.addr)
				prb_pkg::REG_CTRL:   next_st.rd_data = {22'h000000, st.ctrl};
				prb_pkg::REG_STATUS: next_st.rd_data = {27'h0000000, st.first_lock, st.status};
				prb_pkg::REG_IRQ:    next_st.rd_data = {30'h00000000, st.irq_t1, st.irq_e1};
				prb_pkg::REG_BEC:    next_st.rd_data = {16'h0000, st.bec};
				default:             next_st.rd_data = 32'h00000000;
			endcase
		end
		if (bus.rd && bus.addr == prb_pkg::REG_IRQ) begin
			next_st.irq_e1 = 1'b0;
			next_st.irq_t1 = 1'b0;
		end
		if (change) begin
			if (st.ctrl.t1_mode) begin
				next_st.irq_t1 = 1'b1;
			end else begin
				next_st.irq_e1 = 1'b1;
			end
		end
		// clear on read or new enable
		if (mon_rise || (bus.rd && bus.addr == prb_pkg::REG_BEC)) begin
			next_st.bec = {15'h0000, bec_inc};
		end else if (bec_inc) begin
			next_st.bec = st.bec + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st      <= '0;
			st.ctrl <= prb_pkg::CTRL_RST;
			st.gen  <= prb_pkg::GEN_SEED;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_tx_normal_data: assert property (
		@(posedge clk) disable iff (reset)
		(tx_bit_en && !st.ctrl.tx_pattern_enable) |=> tx_line == $past(tx_data))
		else $error("normal data not passed while pattern off");

	a_tx_invert_sel: assert property (
		@(posedge clk) disable iff (reset)
		(tx_bit_en && st.ctrl.tx_pattern_enable)
		|=> tx_line == ($past(gen_bit) ^ $past(st.ctrl.tx_pattern_invert)))
		else $error("transmitted pattern bit wrong");

	a_legacy_poly_sel: assert property (
		@(posedge clk) disable iff (reset)
		(st.ctrl.pattern_mode == 2'h0) |-> (eff_sel == {st.ctrl.legacy_polynomial_select, ~st.ctrl.legacy_polynomial_select}))
		else $error("legacy polynomial choice wrong");

	a_sim_no_pattern: assert property (
		@(posedge clk) disable iff (reset)
		st.ctrl.alarm_sim |=> st.status == prb_pkg::ST_NONE)
		else $error("pattern reported during alarm simulation");

	a_bec_increment: assert property (
		@(posedge clk) disable iff (reset)
		(bit_err && !mon_rise && !bus.rd && st.bec != prb_pkg::BEC_MAX) |=> st.bec == $past(st.bec) + 16'h0001)
		else $error("bit error not counted");

	a_bec_saturate: assert property (
		@(posedge clk) disable iff (reset)
		(st.bec == prb_pkg::BEC_MAX && !mon_rise && !bus.rd) |=> st.bec == prb_pkg::BEC_MAX)
		else $error("error counter wrapped");

	a_ident_irq_repeat: assert property (
		@(posedge clk) disable iff (reset)
		(st.ctrl.rx_pattern_monitor_enable && st.status == prb_pkg::ST_IDENT && !st.ctrl.t1_mode)
		[*2] |=> st.irq_e1)
		else $error("all-zero/ones irq not held set");

	a_status_change_irq: assert property (
		@(posedge clk) disable iff (reset)
		(st.ctrl.rx_pattern_monitor_enable && $changed(st.status) && st.ctrl.t1_mode
		 && $past(st.ctrl.t1_mode) && $past(st.ctrl.rx_pattern_monitor_enable)) |-> st.irq_t1)
		else $error("status change did not set irq");

	a_ident_thresh: assert property (
		@(posedge clk) disable iff (reset)
		(st.ctrl.rx_pattern_monitor_enable && !st.ctrl.alarm_sim && st.ident_run < ident_thr)
		##1 (st.ctrl.rx_pattern_monitor_enable && !st.ctrl.alarm_sim && !mon_rise)
		|-> ##1 (st.status != prb_pkg::ST_IDENT || $past(st.ident_run) >= $past(ident_thr)))
		else $error("all-zero/ones declared too early");

endmodule

// *** sim/prb_remote.sv ***
`timescale 1ns/10ps
module prb_remote (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// stream control from the bench
	input  wire logic [1:0] sel,
	input  wire logic       inv,
	input  wire logic       fixed,
	input  wire logic       fixed_val,
	input  wire logic       flip,
	// line side toward the monitor
	output logic            rx_bit_en,
	output logic            rx_bit
);
	logic [22:0] r;
	logic [1:0]  ph;
	logic        fb;

	always_comb begin
		case (sel)
			2'h0: fb = r[10] ^ r[8];
			2'h1: fb = r[14] ^ r[13];
			2'h2: fb = r[19] ^ r[16];
			default: fb = r[22] ^ r[17];
		endcase
	end

	// one bit every four cycles, no framing
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r         <= 23'h7FFFFF;
			ph        <= 2'h0;
			rx_bit_en <= 1'b0;
			rx_bit    <= 1'b0;
		end else begin
			ph        <= ph + 2'h1;
			rx_bit_en <= (ph == 2'h3);
			// outside its bit slot the line shows the inverse, not a held value
			rx_bit    <= ~rx_bit;
			if (ph == 2'h3) begin
				r      <= {r[21:0], fb};
				rx_bit <= (fixed ? fixed_val : fb ^ inv) ^ flip;
			end
		end
	end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] RA [5]  = '{prb_pkg::REG_CTRL, prb_pkg::REG_STATUS, prb_pkg::REG_IRQ, prb_pkg::REG_BEC, 8'h10};
	localparam int         IDN [4] = '{12, 16, 21, 24};
	logic               clk;
	logic               reset;
	prb_pkg::prb_bus_t  bus;
	logic [31:0]        rd_data;
	logic               tx_bit_en;
	logic               tx_data;
	logic               tx_line;
	logic               rx_bit_en;
	logic               rx_bit;
	logic               loop_status_event;
	logic [1:0]         sel;
	logic               inv;
	logic               fixed;
	logic               fixed_val;
	logic               flip;
	prb_pkg::prb_ctrl_t c;
	logic [22:0]        g;
	logic [31:0]        s;
	logic [31:0]        v;
	int                 n_fail;
	int                 comparisons;

	prb_core prb_core_inst (.clk(clk), .reset(reset), .bus(bus), .rd_data(rd_data), .tx_bit_en(tx_bit_en),
		.tx_data(tx_data), .tx_line(tx_line), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
		.loop_status_event(loop_status_event));
	prb_remote prb_remote_inst (.clk(clk), .reset(reset), .sel(sel), .inv(inv), .fixed(fixed),
		.fixed_val(fixed_val), .flip(flip), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit));

	function automatic logic fb(input logic [22:0] r, input logic [1:0] p);
		case (p)
			2'h0: return r[10] ^ r[8];
			2'h1: return r[14] ^ r[13];
			2'h2: return r[19] ^ r[16];
			default: return r[22] ^ r[17];
		endcase
	endfunction
	function automatic logic [1:0] eff(input prb_pkg::prb_ctrl_t x);
		return (x.pattern_mode == 2'h0) ? {x.legacy_polynomial_select, ~x.legacy_polynomial_select} : x.polynomial_select;
	endfunction
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] seen);
		comparisons++;
		if (seen !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, e, seen);
		end
	endtask
	task automatic wr_ctrl();
		@(posedge clk);
		bus <= '{addr: prb_pkg::REG_CTRL, wr_data: {22'h0, c}, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus <= '{addr: a, wr_data: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 v = rd_data;
	endtask
	task automatic bits(input int n);
		repeat (n) begin
			@(posedge clk);
			while (!rx_bit_en) @(posedge clk);
		end
	endtask
	task automatic tx_run(input int n);
		logic [31:0] x;
		logic        e;
		repeat (n) begin
			x = rnd();
			@(posedge clk);
			tx_bit_en <= 1'b1;
			tx_data   <= x[0];
			e = c.tx_pattern_enable ? fb(g, eff(c)) ^ c.tx_pattern_invert : x[0];
			g = {g[21:0], fb(g, eff(c))};
			@(posedge clk);
			tx_bit_en <= 1'b0;
			#1 chk("tx_line", {31'h0, e}, {31'h0, tx_line});
		end
	endtask
	task automatic pulse();
		@(posedge clk);
		loop_status_event <= 1'b1;
		@(posedge clk);
		loop_status_event <= 1'b0;
	endtask
	task automatic end_of_test();
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset, tx_bit_en, tx_data, loop_status_event, sel, inv, fixed, fixed_val, flip} = 10'h200;
		bus = '0;
		c = '0;
		g = 23'h7FFFFF;
		s = 32'h00000036;
		n_fail = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		foreach (RA[i]) begin
			rd(RA[i]);
			chk("reg_reset", 32'h0, v);
		end
		for (int i = 0; i < 7; i++) begin
			c.pattern_mode = (i < 2) ? 2'h0 : ((i == 5) ? 2'h3 : 2'h1);
			c.legacy_polynomial_select = i[0];
			c.polynomial_select = i[1:0];
			c.tx_pattern_invert = i[0] ^ i[1];
			c.tx_pattern_enable = (i < 6);
			wr_ctrl();
			tx_run(40);
		end
		c = '0;
		for (int t = 0; t < 2; t++) begin
			c.t1_mode = t[0];
			wr_ctrl();
			pulse();
			rd(prb_pkg::REG_IRQ);
			chk("irq_loop", {30'h0, t[0], ~t[0]}, v);
		end
		rd(prb_pkg::REG_IRQ);
		chk("irq_clear", 32'h0, v);
		c = '0;
		c.pattern_mode = 2'h1;
		c.polynomial_select = 2'h1;
		c.rx_pattern_monitor_enable = 1'b1;
		sel <= 2'h1;
		wr_ctrl();
		bits(80);
		rd(prb_pkg::REG_STATUS);
		chk("status_true", 32'h9, v);
		rd(prb_pkg::REG_IRQ);
		chk("irq_lock", 32'h1, v);
		pulse();
		rd(prb_pkg::REG_IRQ);
		chk("irq_source", 32'h0, v);
		rd(prb_pkg::REG_BEC);
		chk("bec_clean", 32'h0, v);
		repeat (3) begin
			bits(2 + int'(rnd() & 32'h7));
			flip <= 1'b1;
			bits(1);
			flip <= 1'b0;
		end
		bits(4);
		rd(prb_pkg::REG_BEC);
		chk("bec_count", 32'h3, v);
		rd(prb_pkg::REG_BEC);
		chk("bec_clear", 32'h0, v);
		c.alarm_sim = 1'b1;
		wr_ctrl();
		bits(2);
		rd(prb_pkg::REG_STATUS);
		chk("status_sim", 32'h0, {29'h0, v[2:0]});
		c.alarm_sim = 1'b0;
		wr_ctrl();
		inv <= 1'b1;
		bits(150);
		rd(prb_pkg::REG_STATUS);
		chk("status_resync", 32'hA, v);
		c.rx_pattern_monitor_enable = 1'b0;
		wr_ctrl();
		c.rx_pattern_monitor_enable = 1'b1;
		wr_ctrl();
		bits(80);
		rd(prb_pkg::REG_STATUS);
		chk("status_inv", 32'h12, v);
		for (int p = 0; p < 4; p++) begin
			c.rx_pattern_monitor_enable = 1'b0;
			wr_ctrl();
			// drop irq bits left over from the inverted lock (p = 0) or the previous all-zero/ones run
			rd(prb_pkg::REG_IRQ);
			c.t1_mode = p[0];
			c.polynomial_select = p[1:0];
			c.tx_pattern_invert = p[0];
			c.rx_pattern_monitor_enable = 1'b1;
			sel <= p[1:0];
			inv <= 1'b0;
			fixed <= 1'b0;
			wr_ctrl();
			bits(80);
			fixed <= 1'b1;
			fixed_val <= ~p[0];
			bits(1);
			fixed_val <= p[0];
			bits(IDN[p] - 1);
			@(posedge clk);
			rd(prb_pkg::REG_STATUS);
			chk("status_run", 32'h9, v);
			bits(1);
			@(posedge clk);
			rd(prb_pkg::REG_STATUS);
			chk("status_ident", 32'hE, v);
			rd(prb_pkg::REG_IRQ);
			chk("irq_ident", {30'h0, p[0], ~p[0]}, v);
			rd(prb_pkg::REG_IRQ);
			chk("irq_again", {30'h0, p[0], ~p[0]}, v);
			// software reads the status once, 30 bits after the fixed stream ends, and checks the all-zero/ones code has gone
			fixed <= 1'b0;
			bits(30);
			@(posedge clk);
			rd(prb_pkg::REG_STATUS);
			chk("status_poll", 32'h0, {31'h0, v[2:1] == 2'h3});
		end
		end_of_test();
	end
endmodule
